// File: rtl/lps_cfg.svh
// Constants of the sense block: offsets, fields, resets, timing.
// Assumes a 50 MHz clock; included by bare name.
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH

// Clock rate in kHz
`define LPS_CLK_KHZ       50000
// Ambient conversion period in ms and in cycles
`define LPS_ALS_CONV_MS   100
`define LPS_ALS_CONV_CYC  (`LPS_ALS_CONV_MS * `LPS_CLK_KHZ)
// Proximity conversion time in us and in cycles
`define LPS_PROX_CONV_US  540
`define LPS_PROX_CONV_CYC (`LPS_PROX_CONV_US * `LPS_CLK_KHZ / 1000)
// Net LED pulse in us and in cycles
`define LPS_LED_ON_US     100
`define LPS_LED_ON_CYC    (`LPS_LED_ON_US * `LPS_CLK_KHZ / 1000)
// Sleep step in ms; eight steps give the longest sleep
`define LPS_SLEEP_STEP_MS 100
`define LPS_SLEEP_MAX_MS  800
`define LPS_SLEEP_STEP_CYC (`LPS_SLEEP_STEP_MS * `LPS_CLK_KHZ)

// Register byte offsets
`define LPS_REG_CTRL      8'h00
`define LPS_REG_ALS_LO    8'h04
`define LPS_REG_ALS_HI    8'h08
`define LPS_REG_PROX_THR  8'h0C
`define LPS_REG_ALS_DATA  8'h10
`define LPS_REG_PROX_DATA 8'h14
`define LPS_REG_IRQ_STAT  8'h18
`define LPS_REG_IRQ_MASK  8'h1C
`define LPS_REG_STATE     8'h20

// Interrupt status and mask bit positions
`define LPS_IRQ_ALS_BIT   0
`define LPS_IRQ_PROX_BIT  1

// Reset values
`define LPS_CTRL_RST      12'h000
`define LPS_ALS_LO_RST    12'h000
`define LPS_ALS_HI_RST    12'hFFF
`define LPS_PROX_THR_RST  8'hFF
`define LPS_IRQ_MASK_RST  2'h3

// Bus responses
`define LPS_RESP_OKAY     2'h0
`define LPS_RESP_SLVERR   2'h2

`endif

// File: rtl/lps_pkg.sv
// Types shared by the light and proximity sense block.
// Assumes nothing beyond a SystemVerilog compiler.
package lps_pkg;

	// Control register layout, bit 11 down to bit 0
	typedef struct packed {
		logic [1:0] prox_persist; // 0:1 1:4 2:8 3:16 consecutive triggers
		logic [1:0] als_persist;  // Same coding for ambient
		logic       resv;         // Reads zero
		logic [2:0] sleep_sel;    // Sleep (n+1) steps between proximity pulses
		logic       led_amp_hi;   // 0: low sink amplitude, 1: high
		logic       als_range_hi; // 0: low lux range, 1: high lux range
		logic       prox_en;      // Proximity sensing on
		logic       als_en;       // Ambient sensing on
	} lps_ctrl_t;

	// One finished conversion, handed to the persistence filter
	typedef struct packed {
		logic valid; // One-cycle pulse
		logic trig;  // Result is in trigger territory
	} lps_eval_t;

	// Proximity sequencer states
	typedef enum logic [1:0] {
		LPS_PX_OFF,
		LPS_PX_CONV,
		LPS_PX_SLEEP
	} lps_px_state_t;

endpackage

// File: rtl/lps_persist.sv
// Consecutive-trigger filter for one sensing channel.
// Assumes eval pulses arrive on aclk; flush is held while the channel is off.
`timescale 1ns/10ps
`default_nettype none

module lps_persist
	import lps_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       flush,    // Channel disabled: forget the run
	input  wire logic [1:0] sel,      // Persistence code
	input  wire lps_eval_t  eval,     // Finished measurement
	output logic            fire      // One-cycle pulse when the run is long enough
);

	// Run length needed for a persistence code
	function automatic logic [4:0] need_of(input logic [1:0] code);
		case (code)
			2'h0: need_of = 5'h01;
			2'h1: need_of = 5'h04;
			2'h2: need_of = 5'h08;
			default: need_of = 5'h10;
		endcase
	endfunction

	logic [4:0] run; // Current consecutive trigger count, saturates at need

	// Counts only unbroken runs; saturating keeps firing on every further trigger
	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			run  <= 5'h00;
			fire <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (eval.valid) begin
				if (!eval.trig) begin
					run <= 5'h00;
				end else if (run + 5'h01 >= need_of(sel)) begin
					run  <= need_of(sel);
					fire <= 1'b1;
				end else begin
					run <= run + 5'h01;
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: rtl/lps_top.sv
// Ambient light and proximity sequencer with interrupt logic and an AXI4-Lite slave.
// Assumes the front end sits on aclk and holds its codes at conversion end;
// the interrupt pin is open-drain with an external pull-up.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lps_cfg.svh"

module lps_top
	import lps_pkg::*;
#(
	parameter int unsigned ADDR_W         = 8,                      // AXI address width
	parameter int unsigned ALS_CONV_CYC   = `LPS_ALS_CONV_CYC,      // Ambient period
	parameter int unsigned PROX_CONV_CYC  = `LPS_PROX_CONV_CYC,     // Proximity conversion
	parameter int unsigned LED_ON_CYC     = `LPS_LED_ON_CYC,        // LED pulse
	parameter int unsigned SLEEP_STEP_CYC = `LPS_SLEEP_STEP_CYC     // One sleep step
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Analog front end
	output logic                   als_convert,     // Ambient converter integrating
	output logic                   als_range_hi,    // Range select to the front end
	input  wire logic [11:0]       als_code,        // Ambient code, valid at conversion end
	output logic                   prox_convert,    // Proximity converter running
	input  wire logic [7:0]        prox_code,       // Proximity code, valid at conversion end
	output logic                   led_sink_drive,  // LED sink on
	output logic                   led_amp_hi,      // Sink amplitude select
	// Interrupt
	output logic                   irq,             // Level, high while unmasked status set
	input  wire logic              int_pin_i,       // Pad level readback
	output logic                   int_pin_o,       // Always low: open-drain
	output logic                   int_pin_oe_n     // Low while pulling the pin low
);

	// Parameters the counters cannot serve
	generate
		if (LED_ON_CYC == 0 || LED_ON_CYC >= PROX_CONV_CYC || ALS_CONV_CYC < 2) begin : g_chk
			$error("lps_top: timing parameters out of range");
		end
		if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk_addr
			$error("lps_top: ADDR_W must cover the register map");
		end
	endgenerate

	localparam logic [31:0] ALS_LAST  = 32'(ALS_CONV_CYC - 1);
	localparam logic [31:0] PROX_LAST = 32'(PROX_CONV_CYC - 1);
	localparam logic [31:0] LED_LEN   = 32'(LED_ON_CYC);

	// Software registers
	lps_ctrl_t   ctrl;      // Enables, ranges, sleep, persistence
	logic [11:0] als_lo;    // Window low limit
	logic [11:0] als_hi;    // Window high limit
	logic [7:0]  prox_thr;  // Proximity threshold
	logic [11:0] als_data;  // Last ambient result
	logic [7:0]  prox_data; // Last proximity result
	logic [1:0]  irq_stat;  // Sticky interrupt status
	logic [1:0]  irq_mask;  // Interrupt enables

	// Write channel holding
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              wr_go;     // Both halves present: perform the write
	logic [31:0]       wr_bytes;  // Write data with unstrobed lanes zero

	// Sequencer state
	logic [31:0]   als_cnt;
	logic          als_done;     // Ambient conversion ends this cycle
	lps_px_state_t px_state;
	logic [31:0]   px_cnt;
	logic          px_done;      // Proximity conversion ends this cycle
	lps_eval_t     als_eval;
	lps_eval_t     prox_eval;
	logic          als_fire;
	logic          prox_fire;

	// Interrupt pin readback synchroniser
	logic int_s1;
	logic int_s2;
	logic int_s3;
	logic int_level;

	// Merge strobed lanes of new data over old
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
		end
	endfunction

	// Address decode shared by read and write paths
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		case (8'(a))
			`LPS_REG_CTRL, `LPS_REG_ALS_LO, `LPS_REG_ALS_HI, `LPS_REG_PROX_THR,
			`LPS_REG_ALS_DATA, `LPS_REG_PROX_DATA, `LPS_REG_IRQ_STAT,
			`LPS_REG_IRQ_MASK, `LPS_REG_STATE: mapped = (a >> 8) == '0;
			default: mapped = 1'b0;
		endcase
	endfunction

	// Sleep length for a sleep code: (code + 1) steps, the top code is the longest
	function automatic logic [31:0] sleep_last(input logic [2:0] code);
		sleep_last = 32'((32'(code) + 32'h1) * SLEEP_STEP_CYC - 1);
	endfunction

	// ---------------- Bus slave ----------------

	// Address and data are taken independently; neither waits for the other
	assign awready  = !aw_held && !bvalid;
	assign wready   = !w_held && !bvalid;
	assign wr_go    = aw_held && w_held && !bvalid;
	assign wr_bytes = merge(32'h0, w_data_q, w_strb_q);
	assign arready  = !rvalid;

	// Write handshake and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `LPS_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (wr_go) begin
				// Unmapped writes get an error and change nothing, except that the IRQ_STAT clear decodes only the low address byte
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= mapped(aw_addr_q) ? `LPS_RESP_OKAY : `LPS_RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Writable configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl     <= lps_ctrl_t'(`LPS_CTRL_RST);
			als_lo   <= `LPS_ALS_LO_RST;
			als_hi   <= `LPS_ALS_HI_RST;
			prox_thr <= `LPS_PROX_THR_RST;
			irq_mask <= `LPS_IRQ_MASK_RST;
		end else if (wr_go && mapped(aw_addr_q)) begin
			case (8'(aw_addr_q))
				`LPS_REG_CTRL: begin
					ctrl      <= lps_ctrl_t'(merge({20'h0, ctrl}, w_data_q, w_strb_q)
						& 32'h0000_0F7F);
				end
				`LPS_REG_ALS_LO: begin
					als_lo <= 12'(merge({20'h0, als_lo}, w_data_q, w_strb_q));
				end
				`LPS_REG_ALS_HI: begin
					als_hi <= 12'(merge({20'h0, als_hi}, w_data_q, w_strb_q));
				end
				`LPS_REG_PROX_THR: begin
					prox_thr <= 8'(merge({24'h0, prox_thr}, w_data_q, w_strb_q));
				end
				`LPS_REG_IRQ_MASK: begin
					irq_mask <= 2'(merge({30'h0, irq_mask}, w_data_q, w_strb_q));
				end
				default: begin
					// Read-only and status registers are handled elsewhere
				end
			endcase
		end
	end

	// Read data: registered so rdata is stable while rvalid waits for rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= `LPS_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= mapped(araddr) ? `LPS_RESP_OKAY : `LPS_RESP_SLVERR;
			case (8'(araddr))
				`LPS_REG_CTRL:      rdata <= {20'h0, ctrl};
				`LPS_REG_ALS_LO:    rdata <= {20'h0, als_lo};
				`LPS_REG_ALS_HI:    rdata <= {20'h0, als_hi};
				`LPS_REG_PROX_THR:  rdata <= {24'h0, prox_thr};
				`LPS_REG_ALS_DATA:  rdata <= {20'h0, als_data};
				`LPS_REG_PROX_DATA: rdata <= {24'h0, prox_data};
				`LPS_REG_IRQ_STAT:  rdata <= {30'h0, irq_stat};
				`LPS_REG_IRQ_MASK:  rdata <= {30'h0, irq_mask};
				`LPS_REG_STATE: begin
					rdata <= {27'h0, int_level, led_sink_drive,
						px_state == LPS_PX_SLEEP, prox_convert, als_convert};
				end
				default:            rdata <= 32'h0;
			endcase
			if (!mapped(araddr)) begin
				rdata <= 32'h0;
			end
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------- Ambient channel ----------------

	// Free-running period counter; runs alongside the proximity sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl.als_en) begin
			als_cnt     <= 32'h0;
			als_convert <= 1'b0;
			als_done    <= 1'b0;
		end else begin
			als_convert <= 1'b1;
			als_done    <= 1'b0;
			if (als_cnt == ALS_LAST) begin
				als_cnt  <= 32'h0;
				als_done <= 1'b1;
			end else begin
				als_cnt <= als_cnt + 32'h1;
			end
		end
	end

	// Range select goes straight to the front end; the code is passed on unscaled
	// so it stays proportional to lux within either range
	assign als_range_hi = ctrl.als_range_hi;

	// Capture the code and judge it against the window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			als_data <= 12'h000;
			als_eval <= '0;
		end else begin
			als_eval.valid <= als_done;
			if (als_done) begin
				als_data      <= als_code;
				als_eval.trig <= (als_code < als_lo) || (als_code > als_hi);
			end
		end
	end

	// ---------------- Proximity channel ----------------

	// Convert, then sleep, then convert again while enabled
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl.prox_en) begin
			px_state <= LPS_PX_OFF;
			px_cnt   <= 32'h0;
			px_done  <= 1'b0;
		end else begin
			px_done <= 1'b0;
			case (px_state)
				LPS_PX_OFF: begin
					px_state <= LPS_PX_CONV;
					px_cnt   <= 32'h0;
				end
				LPS_PX_CONV: begin
					if (px_cnt == PROX_LAST) begin
						px_state <= LPS_PX_SLEEP;
						px_cnt   <= 32'h0;
						px_done  <= 1'b1;
					end else begin
						px_cnt <= px_cnt + 32'h1;
					end
				end
				LPS_PX_SLEEP: begin
					if (px_cnt == sleep_last(ctrl.sleep_sel)) begin
						px_state <= LPS_PX_CONV;
						px_cnt   <= 32'h0;
					end else begin
						px_cnt <= px_cnt + 32'h1;
					end
				end
				default: begin
					px_state <= LPS_PX_OFF;
				end
			endcase
		end
	end

	// Both lag the state one cycle, so px_done falls in the last converting cycle
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl.prox_en) begin
			led_sink_drive <= 1'b0;
			prox_convert   <= 1'b0;
		end else begin
			prox_convert   <= px_state == LPS_PX_CONV;
			led_sink_drive <= (px_state == LPS_PX_CONV) && (px_cnt < LED_LEN);
		end
	end

	assign led_amp_hi = ctrl.led_amp_hi;

	// Capture the code and judge it against the threshold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prox_data <= 8'h00;
			prox_eval <= '0;
		end else begin
			prox_eval.valid <= px_done;
			if (px_done) begin
				prox_data      <= prox_code;
				prox_eval.trig <= prox_code > prox_thr;
			end
		end
	end

	// ---------------- Interrupts ----------------

	// Independent persistence filters per channel
	lps_persist u_als_persist (
		.aclk    (aclk),
		.aresetn (aresetn),
		.flush   (!ctrl.als_en),
		.sel     (ctrl.als_persist),
		.eval    (als_eval),
		.fire    (als_fire)
	);

	lps_persist u_prox_persist (
		.aclk    (aclk),
		.aresetn (aresetn),
		.flush   (!ctrl.prox_en),
		.sel     (ctrl.prox_persist),
		.eval    (prox_eval),
		.fire    (prox_fire)
	);

	// Sticky status, cleared by writing one; a new event in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= 2'h0;
		end else begin
			irq_stat[`LPS_IRQ_ALS_BIT] <= als_fire || (irq_stat[`LPS_IRQ_ALS_BIT]
				&& !(wr_go && 8'(aw_addr_q) == `LPS_REG_IRQ_STAT
				&& wr_bytes[`LPS_IRQ_ALS_BIT]));
			irq_stat[`LPS_IRQ_PROX_BIT] <= prox_fire || (irq_stat[`LPS_IRQ_PROX_BIT]
				&& !(wr_go && 8'(aw_addr_q) == `LPS_REG_IRQ_STAT
				&& wr_bytes[`LPS_IRQ_PROX_BIT]));
		end
	end

	// Pin and level output follow unmasked status; open-drain only ever pulls low
	assign irq          = |(irq_stat & irq_mask);
	assign int_pin_o    = 1'b0;
	assign int_pin_oe_n = !irq;

	// Pad readback: change accepted once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_s1    <= 1'b1;
			int_s2    <= 1'b1;
			int_s3    <= 1'b1;
			int_level <= 1'b1;
		end else begin
			int_s1 <= int_pin_i;
			int_s2 <= int_s1;
			int_s3 <= int_s2;
			if (int_s2 == int_s3) begin
				int_level <= int_s3;
			end
		end
	end

endmodule
`default_nettype wire

// File: verif/lps_afe_model.sv
// Front-end partner: converter codes and the interrupt pad.
// Assumes the bench sets the light levels; the pad has an external pull-up.
`timescale 1ns/10ps
`default_nettype none

module lps_afe_model (
	input  wire logic        als_convert,  // Ambient converter busy
	input  wire logic        prox_convert, // Proximity converter busy
	input  wire logic [11:0] als_val,      // Light level the bench wants seen
	input  wire logic [7:0]  prox_val,     // Reflection level the bench wants seen
	input  wire logic        int_pin_o,    // Pad drive value
	input  wire logic        int_pin_oe_n, // Low while the block pulls the pad
	output logic      [11:0] als_code,     // Code towards the block
	output logic      [7:0]  prox_code,    // Code towards the block
	output logic             int_pin_i     // Resolved pad level
);
	// Codes are only valid while converting; otherwise show the inverse so a
	// late sample is never mistaken for a good one
	assign als_code  = als_convert ? als_val : ~als_val;
	assign prox_code = prox_convert ? prox_val : ~prox_val;
	// Released pad floats up to the pull-up level
	assign int_pin_i = int_pin_oe_n ? 1'b1 : int_pin_o;
endmodule

`default_nettype wire

// File: verif/lps_props.sv
// Port checker of the sense block top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "lps_cfg.svh"

module lps_props #(
	parameter int unsigned PROX_CONV_CYC = `LPS_PROX_CONV_CYC, // Conversion length
	parameter int unsigned LED_ON_CYC    = `LPS_LED_ON_CYC     // LED pulse length
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	input  wire logic        awready,
	input  wire logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid,
	input  wire logic        rready,
	input  wire logic        als_convert,
	input  wire logic        prox_convert,
	input  wire logic        led_sink_drive,
	input  wire logic        irq,
	input  wire logic        int_pin_o,
	input  wire logic        int_pin_oe_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [31:0] plen; // Cycles the current conversion has run
	logic [31:0] llen; // Cycles the current LED pulse has run

	// Run-length counters; long counts cannot be unrolled as repetitions
	always_ff @(posedge aclk) begin
		plen <= (!aresetn || !prox_convert) ? 32'h0 : plen + 32'h1;
		llen <= (!aresetn || !led_sink_drive) ? 32'h0 : llen + 32'h1;
	end

	a_pin_open_drain: assert property (int_pin_oe_n == !irq && int_pin_o == 1'b0)
		else $error("pad does not follow irq");
	a_led_in_conv: assert property (led_sink_drive |-> prox_convert)
		else $error("LED on outside a conversion");
	a_led_len_max: assert property (led_sink_drive |-> llen < LED_ON_CYC)
		else $error("LED pulse too long");
	a_conv_len_max: assert property (prox_convert |-> plen < PROX_CONV_CYC)
		else $error("conversion too long");
	a_sleep_gap_min: assert property ($fell(prox_convert) |-> !prox_convert [*8])
		else $error("sleep too short");
	a_irq_sticky_clear: assert property ($fell(irq) |-> bvalid)
		else $error("irq dropped without a write");
	a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	a_rd_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write not answered");

	c_irq_rise: cover property ($rose(irq));
	c_both_conv: cover property (als_convert && prox_convert);
	c_led_pulse: cover property ($fell(led_sink_drive));
endmodule

bind lps_top lps_props #(.PROX_CONV_CYC(PROX_CONV_CYC), .LED_ON_CYC(LED_ON_CYC)) lps_props_i (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.als_convert(als_convert), .prox_convert(prox_convert),
	.led_sink_drive(led_sink_drive), .irq(irq), .int_pin_o(int_pin_o),
	.int_pin_oe_n(int_pin_oe_n));

`default_nettype wire

// File: verif/lps_top_tb.sv
// Self-checking bench of the sense block.
// Assumes shortened counts through parameters and a 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "lps_cfg.svh"
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t %s", $time, m); end end

module lps_top_tb;
	localparam int ALS = 20, CONV = 12, LED = 4, SLP = 10; // Shortened counts
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic awready, wready, arready, als_convert, prox_convert, led_sink_drive;
	logic als_range_hi, led_amp_hi, irq, int_pin_i, int_pin_o, int_pin_oe_n;
	logic [7:0]  awaddr, araddr, prox_code, prox_val, thr;
	logic [31:0] wdata, rdata, rdat;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	logic [11:0] als_code, als_val, lo, hi;
	int n_mismatch, n_tests, led_n, conv_n, gap_n, last_led, last_conv, last_gap;
	bit pd, pd_bad, both_seen;

	lps_top #(.ALS_CONV_CYC(ALS), .PROX_CONV_CYC(CONV), .LED_ON_CYC(LED), .SLEEP_STEP_CYC(SLP))
	lps_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.als_convert(als_convert), .als_range_hi(als_range_hi), .als_code(als_code),
		.prox_convert(prox_convert), .prox_code(prox_code), .led_sink_drive(led_sink_drive),
		.led_amp_hi(led_amp_hi), .irq(irq), .int_pin_i(int_pin_i), .int_pin_o(int_pin_o),
		.int_pin_oe_n(int_pin_oe_n));
	lps_afe_model lps_afe_model_i (.als_convert(als_convert),
		.prox_convert(prox_convert), .als_val(als_val), .prox_val(prox_val),
		.int_pin_o(int_pin_o), .int_pin_oe_n(int_pin_oe_n), .als_code(als_code),
		.prox_code(prox_code), .int_pin_i(int_pin_i));

	// Clock
	always #10 aclk = ~aclk;

	// Expected figures
	function automatic int persist_n(input logic [1:0] p);
		return (p == 2'h0) ? 1 : (2 << int'(p));
	endfunction
	function automatic logic [31:0] ctrl(input logic ae, pe, rg, am, input logic [2:0] sl,
		input logic [1:0] ap);
		return {22'h0, ap, 1'b0, sl, am, rg, pe, ae};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write: address and data together, response after a random stall
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd, ao, wo;
		{ad, wd} = 2'b00;
		{awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hF, 2'b11};
		while (!(ad && wd)) begin
			@(negedge aclk);
			{ao, wo} = {awvalid && awready, wvalid && wready};
			@(posedge aclk);
			if (ao) begin awvalid <= 1'b0; ad = 1'b1; end
			if (wo) begin wvalid <= 1'b0; wd = 1'b1; end
		end
		cyc($urandom % 3);
		bready <= 1'b1;
		do begin @(negedge aclk); ao = bvalid; rsp = bresp; @(posedge aclk); end while (!ao);
		bready <= 1'b0;
	endtask
	// Read with the same stall on the data channel
	task automatic rd(input logic [7:0] a);
		logic ok;
		araddr <= a;
		arvalid <= 1'b1;
		do begin @(negedge aclk); ok = arready; @(posedge aclk); end while (!ok);
		arvalid <= 1'b0;
		cyc($urandom % 3);
		rready <= 1'b1;
		do begin @(negedge aclk); ok = rvalid; rdat = rdata; rsp = rresp; @(posedge aclk);
		end while (!ok);
		rready <= 1'b0;
	endtask
	// Interrupt output and pad, sampled where settled
	task automatic pin_chk(input logic e);
		@(negedge aclk);
		`CHK(irq, e, "irq level")
		`CHK(int_pin_i, !e, "pad level")
		@(posedge aclk);
	endtask

	// Run lengths of conversions, pulses and gaps, and power-down watch
	always @(negedge aclk) begin
		if (led_sink_drive) led_n++; else if (led_n != 0) begin last_led = led_n; led_n = 0; end
		if (prox_convert) begin
			if (gap_n != 0) last_gap = gap_n;
			gap_n = 0;
			conv_n++;
		end else begin
			if (conv_n != 0) last_conv = conv_n;
			conv_n = 0;
			gap_n++;
		end
		if (als_convert && prox_convert) both_seen = 1'b1;
		if (pd && (als_convert || prox_convert || led_sink_drive)) pd_bad = 1'b1;
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		results();
	end

	initial begin : main
		logic [7:0]  ra [6];
		logic [31:0] rv [6];
		ra = '{`LPS_REG_CTRL, `LPS_REG_ALS_LO, `LPS_REG_ALS_HI, `LPS_REG_PROX_THR,
			`LPS_REG_IRQ_STAT, `LPS_REG_IRQ_MASK};
		rv = '{32'h0, 32'h0, 32'hFFF, 32'hFF, 32'h0, 32'h3};
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, als_val, prox_val} = '0;
		void'($urandom(32'hDCE3));
		cyc(10);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values and an unmapped place
		for (int i = 0; i < 6; i++) begin rd(ra[i]); `CHK(rdat, rv[i], "reset value") end
		rd(8'h24);
		`CHK(rsp, `LPS_RESP_SLVERR, "unmapped read")
		wr(8'h24, 32'h1);
		`CHK(rsp, `LPS_RESP_SLVERR, "unmapped write")
		pin_chk(1'b0);
		$display("test reset done");
		// Window trigger at each persistence code, then sticky status and clear
		for (int p = 0; p < 4; p++) begin
			lo = 12'(1 + $urandom % 2000);
			hi = lo + 12'($urandom % 2000);
			als_val <= ($urandom % 2) ? lo - 12'h1 : hi + 12'h1;
			wr(`LPS_REG_ALS_LO, {20'h0, lo});
			wr(`LPS_REG_ALS_HI, {20'h0, hi});
			wr(`LPS_REG_CTRL, ctrl(1, 0, 0, 0, 0, 2'(p)));
			cyc(persist_n(2'(p)) * ALS - 8);
			rd(`LPS_REG_IRQ_STAT);
			`CHK(rdat[0], 1'b0, "ambient early")
			cyc(16);
			rd(`LPS_REG_IRQ_STAT);
			`CHK(rdat[0], 1'b1, "ambient fired")
			rd(`LPS_REG_ALS_DATA);
			`CHK(rdat, {20'h0, als_val}, "ambient data")
			pin_chk(1'b1);
			wr(`LPS_REG_CTRL, 32'h0);
			cyc(30);
			pin_chk(1'b1);
			wr(`LPS_REG_IRQ_STAT, 32'h1);
			pin_chk(1'b0);
		end
		$display("test ambient persistence done");
		// A boundary sample inside the window breaks a run of four
		als_val <= hi + 12'h1;
		wr(`LPS_REG_CTRL, ctrl(1, 0, 0, 0, 0, 2'h1));
		cyc(70);
		als_val <= lo;
		cyc(20);
		als_val <= hi + 12'h1;
		cyc(60);
		rd(`LPS_REG_IRQ_STAT);
		`CHK(rdat[0], 1'b0, "run not restarted")
		cyc(25);
		rd(`LPS_REG_IRQ_STAT);
		`CHK(rdat[0], 1'b1, "restarted run fired")
		wr(`LPS_REG_CTRL, 32'h0);
		wr(`LPS_REG_IRQ_STAT, 32'h3);
		$display("test ambient run done");
		// Threshold boundary, then masking
		thr = 8'($urandom % 255);
		prox_val <= thr;
		wr(`LPS_REG_PROX_THR, {24'h0, thr});
		wr(`LPS_REG_CTRL, ctrl(0, 1, 0, 0, 0, 0));
		cyc(60);
		rd(`LPS_REG_IRQ_STAT);
		`CHK(rdat[1], 1'b0, "equal to threshold")
		rd(`LPS_REG_PROX_DATA);
		`CHK(rdat, {24'h0, thr}, "proximity data")
		prox_val <= thr + 8'h1;
		cyc(40);
		rd(`LPS_REG_IRQ_STAT);
		`CHK(rdat[1], 1'b1, "above threshold")
		wr(`LPS_REG_IRQ_MASK, 32'h1);
		pin_chk(1'b0);
		wr(`LPS_REG_IRQ_MASK, 32'h3);
		pin_chk(1'b1);
		$display("test proximity done");
		// Every sleep setting, pulse and conversion lengths, both channels together
		for (int s = 0; s < 8; s++) begin
			wr(`LPS_REG_CTRL, ctrl(1, 1, 1'(s >> 1), 1'(s), 3'(s), 0));
			cyc(2 * (CONV + (s + 1) * SLP) + 10);
			@(negedge aclk);
			`CHK(led_amp_hi, 1'(s), "amplitude")
			`CHK(als_range_hi, 1'(s >> 1), "range")
			`CHK(last_gap, (s + 1) * SLP, "sleep length")
			`CHK(last_conv, CONV, "conv length")
			`CHK(last_led, LED, "LED length")
			@(posedge aclk);
		end
		`CHK(both_seen, 1'b1, "concurrent conversions")
		$display("test sleep done");
		// Both enables off: nothing converts or pulses
		wr(`LPS_REG_CTRL, 32'h0);
		cyc(2);
		pd = 1'b1;
		cyc(40);
		pd = 1'b0;
		`CHK(pd_bad, 1'b0, "activity while powered down")
		$display("test power down done");
		results();
	end
endmodule

`default_nettype wire
